// ===== verilog/bsoh_cfg.svh
// opcode handler constants: opcodes, field positions, timing
// assumes inclusion by bare name from the handler and its package users
`ifndef BSOH_CFG_SVH
`define BSOH_CFG_SVH
`define BSOH_OP_PORT 8'h44
`define BSOH_OP_PWRUP 8'h3b
`define BSOH_OP_INHIBIT 8'h18
`define BSOH_OP_KEYED 8'h19
`define BSOH_OP_READY 8'h15
`define BSOH_PORT_CNT 7'h40
`define BSOH_BIT_RESP 1
`define BSOH_BIT_PERIODIC 2
`define BSOH_BIT_INH_LO 0
`define BSOH_BIT_INH_HI 1
`define BSOH_BIT_PRECHG 7
`define BSOH_BIT_KEYED 0
`define BSOH_BIT_LOCKED 6
`define BSOH_BIT_FATAL 7
`define BSOH_BIT_FORM 0
`define BSOH_GROUP_ALL 3'h0
`define BSOH_ADDR_HEAD 8'h05
`define BSOH_ADDR_READY 5'h01
`define BSOH_PERIOD_US 1000
`define BSOH_CLK_MHZ 200
`define BSOH_PERIOD_CYC (`BSOH_PERIOD_US * `BSOH_CLK_MHZ)
`define BSOH_PWRUP_MS 2000
`define BSOH_PWRUP_CYC (`BSOH_PWRUP_MS * 1000 * `BSOH_CLK_MHZ)
`define BSOH_HOLD_MS 500
`define BSOH_HOLD_CYC (`BSOH_HOLD_MS * 1000 * `BSOH_CLK_MHZ)
`endif

// ===== verilog/bsoh_pkg.sv
// types of the bus status opcode handler
// assumes bsoh_cfg.svh for numeric constants
package bsoh_pkg;
    typedef enum logic [2:0] {
        BSOH_IDLE = 3'b000,
        BSOH_SEND = 3'b001
    } bsoh_tx_t;
    typedef struct packed {
        logic [31:0] period_cnt;
        logic [31:0] pwrup_cnt;
        logic [31:0] hold_cnt;
        logic [5:0] per_port;
        logic per_on;
        logic rd_pend;
        logic [5:0] rd_port;
        logic ready_sent;
        logic ready_pend;
        logic stat_pend;
        logic key_pend;
        logic locked;
        logic [1:0] inhibit;
        logic reset_pend;
        logic [7:0] last_key;
        logic tx_valid;
        logic [7:0] tx_op;
        logic [2:0] tx_group;
        logic [4:0] tx_addr;
        logic [7:0] tx_d1;
        logic [7:0] tx_d2;
        logic [7:0] tx_d3;
        logic [7:0] tx_d4;
    } bsoh_state_t;
endpackage : bsoh_pkg

// ===== verilog/bsoh_handler.sv
// message-level handler for port, power-up, inhibit, keyed and ready opcodes
// assumes framing elsewhere: rx is one-cycle strobe per decoded message,
// tx is held until accepted by the framer
`timescale 1ns/1ps
`default_nettype none
`include "bsoh_cfg.svh"
module bsoh_handler (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [2:0] OWN_GROUP,
    input wire logic [4:0] OWN_ADDR,
    input wire logic [31:0] GROUP_MEMBERS,
    input wire logic FORM_MOBILE,
    input wire logic [7:0] SELF_TEST_FLAGS,
    input wire logic SELF_TEST_ERROR,
    input wire logic RX_VALID,
    input wire logic [7:0] RX_OPCODE,
    input wire logic [2:0] RX_GROUP,
    input wire logic [4:0] RX_ADDR,
    input wire logic [7:0] RX_D1,
    input wire logic [7:0] RX_D2,
    input wire logic [7:0] RX_D3,
    input wire logic [7:0] RX_D4,
    input wire logic [63:0] PORT_IMPL,
    output logic [5:0] PORT_SEL,
    input wire logic [7:0] PORT_VALUE,
    input wire logic PORT_READY,
    input wire logic KEYED,
    input wire logic ABOUT_TO_DEKEY,
    input wire logic TIMEOUT_EXPIRED,
    output logic TX_VALID,
    input wire logic TX_READY,
    output logic [7:0] TX_OPCODE,
    output logic [2:0] TX_GROUP,
    output logic [4:0] TX_ADDR,
    output logic [7:0] TX_D1,
    output logic [7:0] TX_D2,
    output logic [7:0] TX_D3,
    output logic [7:0] TX_D4,
    output logic RADIO_READY,
    output logic AUDIO_MUTE,
    output logic TX_ALLOWED,
    output logic [1:0] TALK_INHIBIT,
    output logic SYS_RESET_REQ
);
    bsoh_pkg::bsoh_state_t s_reg;
    bsoh_pkg::bsoh_state_t s_next;
    logic [31:0] seen_reg;
    logic [31:0] seen_next;
    logic rx_mine;
    logic rx_port_req;

    // valid port check, used on the request path only
    function automatic logic port_ok(input logic [63:0] impl,
                                     input logic [5:0] num);
        port_ok = impl[num];
    endfunction : port_ok

    // ---------------------------------------------------------------
    // receive decode
    // ---------------------------------------------------------------
    // a port request is addressed to us and carries response flag clear
    assign rx_mine = (RX_GROUP == OWN_GROUP) && (RX_ADDR == OWN_ADDR);
    // the periodic flag is left for the next-state logic to act upon
    assign rx_port_req = RX_VALID && RX_OPCODE == `BSOH_OP_PORT && rx_mine
        && !RX_D2[`BSOH_BIT_RESP];

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    // one message at a time; priority: status, ready, keyed, port
    // the transmit slot is worked out first, so that an event setting a
    // pending flag in the same cycle as the slot clears it still wins;
    // otherwise a status error or a key change could be lost for good
    always_comb begin
        s_next = s_reg;
        seen_next = seen_reg;
        // transmit slot: fields are loaded only while the slot is empty
        if (s_reg.tx_valid && TX_READY) begin
            s_next.tx_valid = 1'b0;
        end else if (!s_reg.tx_valid) begin
            s_next.tx_group = OWN_GROUP;
            s_next.tx_addr = OWN_ADDR;
            s_next.tx_d1 = 8'h00;
            s_next.tx_d2 = 8'h00;
            s_next.tx_d3 = 8'h00;
            s_next.tx_d4 = 8'h00;
            if (s_reg.stat_pend) begin
                s_next.stat_pend = 1'b0;
                s_next.tx_valid = 1'b1;
                s_next.tx_op = `BSOH_OP_PWRUP;
                s_next.tx_group = `BSOH_GROUP_ALL;
                s_next.tx_d1 = SELF_TEST_FLAGS;
            end else if (s_reg.ready_pend) begin
                s_next.ready_pend = 1'b0;
                s_next.tx_valid = 1'b1;
                s_next.tx_op = `BSOH_OP_READY;
                s_next.tx_addr = `BSOH_ADDR_READY;
                s_next.tx_d2 = {7'h00, FORM_MOBILE};
            end else if (s_reg.key_pend && s_reg.ready_sent) begin
                s_next.key_pend = 1'b0;
                s_next.tx_valid = 1'b1;
                s_next.tx_op = `BSOH_OP_KEYED;
                s_next.tx_d1 = {s_reg.last_key[1], 6'h00,
                                s_reg.last_key[0]};
            end else if (s_reg.rd_pend && PORT_READY) begin
                // a slow port source simply holds the reply back
                s_next.rd_pend = 1'b0;
                s_next.tx_valid = 1'b1;
                s_next.tx_op = `BSOH_OP_PORT;
                s_next.tx_d1 = PORT_VALUE;
                s_next.tx_d2 = 8'h01 << `BSOH_BIT_RESP;
                s_next.tx_d4 = {2'b00, s_reg.rd_port};
            end
        end
        // timers count down to zero and rest there
        if (s_reg.period_cnt != 32'h0) begin
            s_next.period_cnt = s_reg.period_cnt - 32'h1;
        end
        if (s_reg.hold_cnt != 32'h0) begin
            s_next.hold_cnt = s_reg.hold_cnt - 32'h1;
        end
        if (!s_reg.ready_sent && s_reg.pwrup_cnt != 32'h0) begin
            s_next.pwrup_cnt = s_reg.pwrup_cnt - 32'h1;
        end
        if (SELF_TEST_ERROR) begin
            s_next.stat_pend = 1'b1;
        end
        // flags in rx: periodic is bit 2 of the flag byte (RX_D2 carries flags)
        if (rx_port_req) begin
            if (port_ok(PORT_IMPL, RX_D4[5:0])
                    && RX_D4 < {1'b0, `BSOH_PORT_CNT}) begin
                s_next.rd_pend = 1'b1;
                s_next.rd_port = RX_D4[5:0];
                if (RX_D2[`BSOH_BIT_PERIODIC]) begin
                    s_next.per_on = 1'b1;
                    s_next.per_port = RX_D4[5:0];
                    s_next.period_cnt = `BSOH_PERIOD_CYC;
                end else begin
                    s_next.per_on = 1'b0;
                end
            end
        end
        if (RX_VALID && RX_OPCODE == `BSOH_OP_PWRUP) begin
            seen_next[RX_ADDR] = 1'b1;
            if ({3'h0, RX_ADDR} == `BSOH_ADDR_HEAD) begin
                s_next.locked = RX_D1[`BSOH_BIT_LOCKED];
            end
            if (RX_D1[`BSOH_BIT_FATAL] && s_reg.hold_cnt == 32'h0) begin
                s_next.reset_pend = 1'b1;
                s_next.hold_cnt = `BSOH_HOLD_CYC;
            end
            if (s_reg.ready_sent) begin
                s_next.ready_pend = 1'b1;
            end
        end
        if (RX_VALID && RX_OPCODE == `BSOH_OP_INHIBIT
                && RX_GROUP == `BSOH_GROUP_ALL) begin
            // the invalid code 10 is dropped, current state kept
            if (RX_D1[1:0] != 2'b10) begin
                s_next.inhibit = RX_D1[1:0];
            end
        end
        // keyed messages from the bus are never acted upon here
        if (!s_reg.ready_sent && ((seen_reg | seen_next) & GROUP_MEMBERS)
                == GROUP_MEMBERS || s_reg.pwrup_cnt == 32'h0) begin
            if (!s_reg.ready_sent) begin
                s_next.ready_pend = 1'b1;
                s_next.ready_sent = 1'b1;
            end
        end
        if (s_reg.per_on && s_reg.period_cnt == 32'h0 && !s_reg.rd_pend) begin
            s_next.rd_pend = 1'b1;
            s_next.rd_port = s_reg.per_port;
            s_next.period_cnt = `BSOH_PERIOD_CYC;
        end
        if ({ABOUT_TO_DEKEY, KEYED} != s_reg.last_key[1:0]
                || TIMEOUT_EXPIRED) begin
            s_next.key_pend = 1'b1;
        end
        // the 10 code cannot arise: the pre-change bit needs keyed set
        s_next.last_key = {6'h0, ABOUT_TO_DEKEY & KEYED, KEYED};
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    // reset clears periodic polling and inhibit, and queues own status
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            s_reg <= '0;
            s_reg.stat_pend <= 1'b1;
            s_reg.pwrup_cnt <= `BSOH_PWRUP_CYC;
            seen_reg <= 32'h0;
        end else begin
            s_reg <= s_next;
            seen_reg <= seen_next;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign PORT_SEL = s_reg.rd_port;
    assign TX_VALID = s_reg.tx_valid;
    assign TX_OPCODE = s_reg.tx_op;
    assign TX_GROUP = s_reg.tx_group;
    assign TX_ADDR = s_reg.tx_addr;
    assign TX_D1 = s_reg.tx_d1;
    assign TX_D2 = s_reg.tx_d2;
    assign TX_D3 = s_reg.tx_d3;
    assign TX_D4 = s_reg.tx_d4;
    assign RADIO_READY = s_reg.ready_sent;
    // muted before ready or while the keypad is locked
    assign AUDIO_MUTE = !s_reg.ready_sent || s_reg.locked;
    assign TX_ALLOWED = s_reg.ready_sent && !s_reg.locked
        && !s_reg.inhibit[`BSOH_BIT_INH_LO];
    assign TALK_INHIBIT = s_reg.inhibit;
    // reset request waits out the display hold
    assign SYS_RESET_REQ = s_reg.reset_pend && s_reg.hold_cnt == 32'h0;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    AST_PWRUP_GROUP: assert property (@(posedge CLK) disable iff (!RST_B)
        TX_VALID && TX_OPCODE == `BSOH_OP_PWRUP |-> TX_GROUP == `BSOH_GROUP_ALL)
        else $error("status not sent to group zero");
    AST_READY_ADDR: assert property (@(posedge CLK) disable iff (!RST_B)
        TX_VALID && TX_OPCODE == `BSOH_OP_READY |-> TX_ADDR == `BSOH_ADDR_READY
        && TX_D2[0] == FORM_MOBILE) else $error("ready fields wrong");
    AST_PORT_RESP: assert property (@(posedge CLK) disable iff (!RST_B)
        TX_VALID && TX_OPCODE == `BSOH_OP_PORT |-> TX_D2[1]
        && TX_ADDR == OWN_ADDR) else $error("port reply flags wrong");
    AST_KEY_CODE: assert property (@(posedge CLK) disable iff (!RST_B)
        TX_VALID && TX_OPCODE == `BSOH_OP_KEYED |-> !(TX_D1[7] && !TX_D1[0]))
        else $error("keyed code 10 sent");
    AST_MUTE_EARLY: assert property (@(posedge CLK) disable iff (!RST_B)
        !RADIO_READY |-> AUDIO_MUTE && !TX_ALLOWED)
        else $error("not muted before ready");
    AST_NO_KEY_EARLY: assert property (@(posedge CLK) disable iff (!RST_B)
        TX_VALID && TX_OPCODE == `BSOH_OP_KEYED |-> RADIO_READY)
        else $error("keyed sent before ready");
    AST_INH_NOINV: assert property (@(posedge CLK) disable iff (!RST_B)
        TALK_INHIBIT != 2'b10) else $error("invalid inhibit held");
    AST_REREADY: assert property (@(posedge CLK) disable iff (!RST_B)
        RX_VALID && RX_OPCODE == `BSOH_OP_PWRUP && RADIO_READY |=> s_reg.ready_pend
        || (TX_VALID && TX_OPCODE == `BSOH_OP_READY))
        else $error("ready not requeued");
    // a stalled message must not change under the framer's feet
    AST_TX_HOLD: assert property (@(posedge CLK) disable iff (!RST_B)
        TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_OPCODE)
        && $stable(TX_D1) && $stable(TX_D4)) else $error("tx changed in stall");
    // a fresh fatal error never resets at once; the display needs time
    AST_FATAL_HOLD: assert property (@(posedge CLK) disable iff (!RST_B)
        $rose(s_reg.reset_pend) |-> !SYS_RESET_REQ)
        else $error("reset not held back");
    COV_PORT: cover property (@(posedge CLK) TX_VALID && TX_OPCODE == `BSOH_OP_PORT);
    COV_KEYED: cover property (@(posedge CLK) TX_VALID && TX_OPCODE == `BSOH_OP_KEYED);
    COV_READY: cover property (@(posedge CLK) $rose(RADIO_READY));
    COV_LOCK: cover property (@(posedge CLK) s_reg.locked);
endmodule : bsoh_handler
`default_nettype wire

// ===== verification/bsoh_bus_model.sv
// bus-side partner: decoded receive strobes, framer ready, port sources
// assumes the handler samples everything on the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module bsoh_bus_model (
    input wire logic clk,
    output logic rx_valid,
    output logic [7:0] rx_op,
    output logic [2:0] rx_grp,
    output logic [4:0] rx_adr,
    output logic [7:0] rx_d1,
    output logic [7:0] rx_d2,
    output logic [7:0] rx_d3,
    output logic [7:0] rx_d4,
    output logic tx_ready,
    input wire logic [5:0] port_sel,
    output logic [7:0] port_value,
    output logic port_ready
);
    // ----------------------------------------
    // port sources and framer
    // ----------------------------------------
    logic [5:0] sel_reg = 6'h3f;
    logic [2:0] wait_reg = 3'h0;
    logic [2:0] lat_reg = 3'h2;
    function automatic logic [7:0] port_pattern(input logic [5:0] p);
        return {2'b10, p} ^ 8'h3c;
    endfunction : port_pattern
    initial begin
        rx_valid = 1'b0;
        {rx_op, rx_grp, rx_adr, rx_d1, rx_d2, rx_d3, rx_d4} = '0;
    end
    // random stalls keep the held transmit fields under test
    always @(posedge clk) tx_ready <= ($urandom % 3) == 0;
    // a new port needs a random conversion time, prompt or slow
    always @(posedge clk) begin
        if (sel_reg != port_sel) begin
            sel_reg <= port_sel;
            wait_reg <= 3'h0;
            lat_reg <= 3'($urandom);
        end else if (wait_reg != lat_reg) begin
            wait_reg <= wait_reg + 3'h1;
        end
    end
    assign port_ready = (sel_reg == port_sel) && (wait_reg == lat_reg);
    // scrambled until ready, so an early sample is caught
    assign port_value = port_ready ? port_pattern(port_sel)
        : ~port_pattern(port_sel) ^ {5'h00, wait_reg};
    // one decoded message per call; D1 and D4 lines turn over afterwards
    task automatic send(input logic [7:0] op, input logic [2:0] grp,
        input logic [4:0] adr, input logic [7:0] d1, input logic [7:0] d2,
        input logic [7:0] d4);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_op <= op;
        rx_grp <= grp;
        rx_adr <= adr;
        rx_d1 <= d1;
        rx_d2 <= d2;
        rx_d3 <= 8'($urandom);
        rx_d4 <= d4;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_d1 <= ~d1;
        rx_d4 <= ~d4;
        @(posedge clk);
    endtask : send
endmodule : bsoh_bus_model
`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench of the opcode handler against a bus-side model
// assumes bsoh_handler and bsoh_bus_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ----------------------------------------
    // expectations, checks and stimulus
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] op;
        logic [2:0] grp;
        logic [4:0] adr;
        logic [7:0] d1;
        logic [7:0] d2;
        logic [7:0] d2m;
        logic [7:0] d4;
        logic [4:0] care;
    } bsoh_exp_t;
    localparam logic [2:0] OWN_G = 3'h1;
    localparam logic [4:0] OWN_A = 5'h01;
    bsoh_exp_t exp_q[$];
    int error_cnt = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic form = 1'b0;
    logic st_err = 1'b0;
    logic keyed = 1'b0;
    logic dekey = 1'b0;
    logic transmit_timeout_timer = 1'b0;
    logic [7:0] st_flags = 8'h00;
    logic rx_valid, tx_valid, tx_ready, port_ready, rdy, mute, allow, rreq;
    logic [7:0] rx_op, rx_d1, rx_d2, rx_d3, rx_d4, port_value;
    logic [7:0] tx_op, tx_d1, tx_d2, tx_d4;
    logic [2:0] rx_grp, tx_grp;
    logic [4:0] rx_adr, tx_adr;
    logic [5:0] port_sel;
    logic [1:0] inh;
    bsoh_handler i_dut (.CLK(clk), .RST_B(rst_b), .OWN_GROUP(OWN_G),
        .OWN_ADDR(OWN_A), .GROUP_MEMBERS(32'h0000_00a0), .FORM_MOBILE(form),
        .SELF_TEST_FLAGS(st_flags), .SELF_TEST_ERROR(st_err),
        .RX_VALID(rx_valid), .RX_OPCODE(rx_op), .RX_GROUP(rx_grp),
        .RX_ADDR(rx_adr), .RX_D1(rx_d1), .RX_D2(rx_d2), .RX_D3(rx_d3),
        .RX_D4(rx_d4), .PORT_IMPL(64'h7fff_ffff_ffff_ffff),
        .PORT_SEL(port_sel), .PORT_VALUE(port_value),
        .PORT_READY(port_ready), .KEYED(keyed), .ABOUT_TO_DEKEY(dekey),
        .TIMEOUT_EXPIRED(transmit_timeout_timer), .TX_VALID(tx_valid), .TX_READY(tx_ready),
        .TX_OPCODE(tx_op), .TX_GROUP(tx_grp), .TX_ADDR(tx_adr),
        .TX_D1(tx_d1), .TX_D2(tx_d2), .TX_D3(), .TX_D4(tx_d4),
        .RADIO_READY(rdy), .AUDIO_MUTE(mute), .TX_ALLOWED(allow),
        .TALK_INHIBIT(inh), .SYS_RESET_REQ(rreq));
    bsoh_bus_model i_bus (.clk(clk), .rx_valid(rx_valid), .rx_op(rx_op),
        .rx_grp(rx_grp), .rx_adr(rx_adr), .rx_d1(rx_d1), .rx_d2(rx_d2),
        .rx_d3(rx_d3), .rx_d4(rx_d4), .tx_ready(tx_ready),
        .port_sel(port_sel), .port_value(port_value),
        .port_ready(port_ready));
    initial forever #2.5 clk = ~clk;
    task automatic cmp(input string what, input logic [7:0] e, logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : cmp
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    // wait for all expected transmits, then a quiet spell for strays
    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        cmp("tx_pending", 8'h00, 8'(exp_q.size()));
        repeat (8) @(posedge clk);
    endtask : drain
    task automatic ready_exp();
        exp_q.push_back('{8'h15, 3'h0, 5'h01, 8'h00, {7'h00, form}, 8'h01,
            8'h00, 5'b10100});
    endtask : ready_exp
    // each accepted transmit is matched to the oldest note; hang guard
    always @(posedge clk) begin
        bsoh_exp_t e;
        cycles++;
        if (rst_b === 1'b1 && tx_valid === 1'b1 && tx_ready === 1'b1) begin
            e = exp_q.size() != 0 ? exp_q.pop_front() : '0;
            cmp("tx_opcode", e.op, tx_op);
            if (e.care[3]) cmp("tx_group", {5'h00, e.grp}, {5'h00, tx_grp});
            if (e.care[2]) cmp("tx_addr", {3'h0, e.adr}, {3'h0, tx_adr});
            if (e.care[1]) cmp("tx_d1", e.d1, tx_d1);
            if (e.care[0]) cmp("tx_d4", e.d4, tx_d4);
            cmp("tx_d2", e.d2 & e.d2m, tx_d2 & e.d2m);
        end
        if (cycles == 20000) begin
            error_cnt++;
            $display("BAD run_cycles expected 20000 seen more");
            conclude();
        end
    end
    initial begin
        logic [1:0] codes [6] = '{2'b01, 2'b11, 2'b11, 2'b10, 2'b00, 2'b01};
        logic [1:0] held [6] = '{2'b01, 2'b11, 2'b11, 2'b11, 2'b00, 2'b01};
        logic [7:0] keys [3] = '{8'h01, 8'h81, 8'h00};
        logic [7:0] pfl [5] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h00};
        logic [5:0] ports [5];
        logic [7:0] f;
        void'($urandom(32'h6446));
        form = 1'($urandom);
        st_flags = 8'($urandom) & 8'h3f;
        ports = '{6'h00, 6'h3e, 6'($urandom % 62), 6'h05, 6'h05};
        repeat (4) @(posedge clk);
        cmp("talk_inhibit", 8'h00, {6'h00, inh});
        cmp("audio_mute", 8'h01, {7'h00, mute});
        cmp("tx_allowed", 8'h00, {7'h00, allow});
        exp_q.push_back('{8'h3b, 3'h0, 5'h00, st_flags, 8'h00, 8'h00, 8'h00,
            5'b11010});
        rst_b <= 1'b1;
        drain();
        i_bus.send(8'h3b, 3'h0, 5'h05, 8'h40, 8'h00, 8'h00);
        drain();
        cmp("radio_ready", 8'h00, {7'h00, rdy});
        ready_exp();
        i_bus.send(8'h3b, 3'h0, 5'h07, 8'h00, 8'h00, 8'h00);
        drain();
        cmp("radio_ready", 8'h01, {7'h00, rdy});
        cmp("audio_mute", 8'h01, {7'h00, mute});
        ready_exp();
        i_bus.send(8'h3b, 3'h0, 5'h05, 8'h00, 8'h00, 8'h00);
        drain();
        cmp("audio_mute", 8'h00, {7'h00, mute});
        cmp("tx_allowed", 8'h01, {7'h00, allow});
        f = 8'($urandom) & 8'h3f;
        exp_q.push_back('{8'h3b, 3'h0, 5'h00, f, 8'h00, 8'h00, 8'h00,
            5'b11010});
        st_flags <= f;
        st_err <= 1'b1;
        @(posedge clk);
        st_err <= 1'b0;
        drain();
        $display("test power-up and ready done");
        for (int i = 0; i < 3; i++) begin
            exp_q.push_back('{8'h19, 3'h0, 5'h00, keys[i], 8'h00, 8'h00,
                8'h00, 5'b10010});
            keyed <= keys[i][0];
            dekey <= keys[i][7];
            drain();
        end
        exp_q.push_back('{8'h19, 3'h0, 5'h00, 8'h00, 8'h00, 8'h00, 8'h00,
            5'b10010});
        transmit_timeout_timer <= 1'b1;
        @(posedge clk);
        transmit_timeout_timer <= 1'b0;
        drain();
        i_bus.send(8'h19, OWN_G, 5'h09, 8'h01, 8'h00, 8'h00);
        drain();
        $display("test keyed done");
        for (int i = 0; i < 6; i++) begin
            i_bus.send(8'h18, 3'h0, 5'h0a, {6'($urandom), codes[i]}, 8'h00,
                8'h00);
            drain();
            cmp("talk_inhibit", {6'h00, held[i]}, {6'h00, inh});
            cmp("tx_allowed", {7'h00, !held[i][0]}, {7'h00, allow});
        end
        $display("test inhibit done");
        for (int i = 0; i < 5; i++) begin
            exp_q.push_back('{8'h44, OWN_G, OWN_A,
                i_bus.port_pattern(ports[i]), 8'h02, 8'h02,
                {2'h0, ports[i]}, 5'b11111});
            i_bus.send(8'h44, OWN_G, OWN_A, 8'($urandom), pfl[i],
                {2'h0, ports[i]});
            drain();
        end
        i_bus.send(8'h44, OWN_G, OWN_A, 8'h00, 8'h00, 8'h3f);
        i_bus.send(8'h44, OWN_G, 5'h0b, 8'h00, 8'h00, 8'h01);
        drain();
        $display("test ports done");
        ready_exp();
        i_bus.send(8'h3b, 3'h0, 5'h07, 8'h80, 8'h00, 8'h00);
        drain();
        cmp("sys_reset_req", 8'h00, {7'h00, rreq});
        $display("test fatal done");
        conclude();
    end
endmodule : tb_top
`default_nettype wire
